// ===== core/tux_down_timer.sv
// one 8-bit reload down-counter with latch
`timescale 1ns/1ns
module tux_down_timer
   import tux_pkg::*;
(
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       sys_rst,
   // control
   input  wire logic       tick,
   input  wire logic       load,
   input  wire logic [7:0] load_val,
   // state
   output logic [7:0]      count,
   output logic            underflow
);
   logic [7:0] latch;
   logic [7:0] next_latch;
   logic [7:0] next_count;
   logic       next_underflow;

   always_comb
   begin
      next_latch     = latch;
      next_count     = count;
      next_underflow = 1'b0;
      if (load)
      begin
         // a write sets latch and counter together
         next_latch = load_val;
         next_count = load_val;
      end
      else if (tick)
      begin
         if (count == 8'h00)
         begin
            next_count     = latch;
            next_underflow = 1'b1;
         end
         else
         begin
            next_count = count - 8'h01;
         end
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         latch     <= TMR_RST;
         count     <= TMR_RST;
         underflow <= 1'b0;
      end
      else
      begin
         latch     <= next_latch;
         count     <= next_count;
         underflow <= next_underflow;
      end
   end
endmodule : tux_down_timer

// ===== core/tux_pkg.sv
// package with register map, field layout and carriers of the timer unit
package tux_pkg;
   // register indexes; byte address is four times the index
   localparam logic [7:0] IDX_TMR1 = 8'h21;
   localparam logic [7:0] IDX_TMR2 = 8'h22;
   localparam logic [7:0] IDX_MODE = 8'h23;
   localparam logic [7:0] IDX_TMRX = 8'h25;
   localparam logic [7:0] IDX_TMRY = 8'h27;
   localparam logic [7:0] IDX_CSS  = 8'h28;
   localparam logic [7:0] IDX_IEN1 = 8'h3E;
   localparam logic [7:0] IDX_STAT = 8'h40;
   localparam logic [7:0] IDX_CLR  = 8'h41;
   localparam logic [7:0] IDX_EN   = 8'h42;
   localparam logic [7:0] IDX_CTRL = 8'h43;

   localparam int ADR_W = 10;
   localparam int NUM_TMR = 4;
   localparam int NUM_EVT = 6;

   // count source select fields
   localparam int CSS_X = 0;
   localparam int CSS_Y = 1;
   localparam int CSS_12 = 2;
   localparam logic [7:0] CSS_MASK = 8'h07;
   // irq enable one fields for the two pin timers
   localparam int IEN1_X = 6;
   localparam int IEN1_Y = 7;
   // control register: low-speed mode bit
   localparam int CTRL_LOW_SPEED = 0;
   // operating mode field layout per pin timer, timer y sits 4 bits higher
   localparam int MODE_STRIDE = 4;
   localparam int MODE_EDGE = 2;
   localparam int MODE_STOP = 3;
   // timer indexes and event bits
   localparam int T_X = 0;
   localparam int T_Y = 1;
   localparam int T_1 = 2;
   localparam int T_2 = 3;
   localparam int EVT_PIN0 = 4;

   localparam logic [7:0] REG_RST = 8'h00;
   localparam logic [7:0] TMR_RST = 8'hFF;
   localparam logic [3:0] DIV16_LAST = 4'hF;

   typedef enum logic [1:0] {
      TUX_MODE_TIMER,
      TUX_MODE_PULSE,
      TUX_MODE_EVENT,
      TUX_MODE_WIDTH
   } tux_mode_t;

   typedef struct packed {
      logic             cyc;
      logic             stb;
      logic             we;
      logic [ADR_W-1:0] adr;
      logic [3:0]       sel;
      logic [31:0]      dat;
   } tux_wb_req_t;

   typedef struct packed {
      logic       pin_o;
      logic       pin_oe_n;
   } tux_pin_drv_t;
endpackage : tux_pkg

// ===== core/tux_timer_unit.sv
// four reload timers with pin modes, wishbone registers and interrupt
//
// Behaviour
// - bit0 picks timer x /16 or /2
// - bit1 picks timer y, same encoding
// - low-speed mode divides sub-oscillator instead
// - bit2 picks timers 1,2: /16 or sub-oscillator
// - select bits 3..7 unimplemented; reset zero
// - enable bit6 gates timer x interrupt
// - enable bit7 gates timer y interrupt
// - other enable bits stored, read/write, reset zero
// - interrupt when programmed interval elapses
// - underflow reloads counter from latch
// - pulse mode toggles pin on underflow
// - event mode counts external pin edges
// - width mode counts while pin at level
// - mode fields: timer, pulse, event, width
// - stop bit halts counting; mode resets zero
// - edge bit: start level, count edge, irq edge
// - width: 0 high/falling, 1 low/rising
`timescale 1ns/1ns
module tux_timer_unit
   import tux_pkg::*;
(
   // clock and reset
   input  wire logic          ref_clk,
   input  wire logic          sys_rst,
   // wishbone slave
   input  tux_wb_req_t        wb_req,
   output logic               wb_ack_o,
   output logic [31:0]        wb_dat_o,
   // oscillator inputs, sampled as levels
   input  wire logic          main_osc_input,
   input  wire logic          sub_osc_input,
   // external timer pins
   input  wire logic          ext_timer_pin_zero_i,
   output tux_pin_drv_t       ext_timer_pin_zero,
   input  wire logic          ext_timer_pin_one_i,
   output tux_pin_drv_t       ext_timer_pin_one,
   // interrupt
   output logic               irq
);
   function automatic logic hit(input logic [ADR_W-1:0] adr, input logic [7:0] idx);
      hit = (adr == {idx, 2'b00});
   endfunction : hit
   // synchronisers for pins and oscillators
   logic [3:0] sync_a;
   logic [3:0] sync_b;
   logic [3:0] sync_c;
   logic [3:0] raw_in;
   assign raw_in = {ext_timer_pin_one_i, ext_timer_pin_zero_i, sub_osc_input, main_osc_input};

   // first stage feeds only the second; third stage is for edge detection
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         sync_a <= 4'h0;
         sync_b <= 4'h0;
         sync_c <= 4'h0;
      end
      else
      begin
         sync_a <= raw_in;
         sync_b <= sync_a;
         sync_c <= sync_b;
      end
   end

   logic [1:0] pin_lvl;
   logic [1:0] pin_rise;
   logic [1:0] pin_fall;
   logic       main_rise;
   logic       sub_rise;
   assign main_rise = sync_b[0] & ~sync_c[0];
   assign sub_rise  = sync_b[1] & ~sync_c[1];
   assign pin_lvl   = sync_b[3:2];
   assign pin_rise  = sync_b[3:2] & ~sync_c[3:2];
   assign pin_fall  = ~sync_b[3:2] & sync_c[3:2];
   // registers
   logic [7:0]         css;
   logic [7:0]         ien1;
   logic [7:0]         mode;
   logic [7:0]         ctrl;
   logic [NUM_EVT-1:0] stat;
   logic [NUM_EVT-1:0] evt_en;
   logic [7:0]         next_css;
   logic [7:0]         next_ien1;
   logic [7:0]         next_mode;
   logic [7:0]         next_ctrl;
   logic [NUM_EVT-1:0] next_stat;
   logic [NUM_EVT-1:0] next_evt_en;
   logic               next_ack;
   logic [31:0]        next_dat;
   logic               next_irq;
   logic               wr;
   logic [7:0]         wdat;
   logic [NUM_TMR-1:0] tmr_load;
   logic [7:0]         tmr_cnt [NUM_TMR];
   logic [NUM_TMR-1:0] tmr_uf;
   logic [NUM_TMR-1:0] tmr_tick;
   logic [1:0]         pin_evt;
   logic [NUM_EVT-1:0] evt_gate;
   assign wr   = wb_req.cyc & wb_req.stb & wb_req.we & wb_ack_o & wb_req.sel[0];
   assign wdat = wb_req.dat[7:0];
   assign tmr_load[T_X] = wr & hit(wb_req.adr, IDX_TMRX);
   assign tmr_load[T_Y] = wr & hit(wb_req.adr, IDX_TMRY);
   assign tmr_load[T_1] = wr & hit(wb_req.adr, IDX_TMR1);
   assign tmr_load[T_2] = wr & hit(wb_req.adr, IDX_TMR2);

   always_comb
   begin
      next_css    = css;
      next_ien1   = ien1;
      next_mode   = mode;
      next_ctrl   = ctrl;
      next_evt_en = evt_en;
      // hardware set wins over a clear in the same cycle
      next_stat   = stat | {pin_evt, tmr_uf};
      if (wr)
      begin
         if (hit(wb_req.adr, IDX_CSS))
         begin
            next_css = wdat & CSS_MASK;
         end
         else if (hit(wb_req.adr, IDX_IEN1))
         begin
            next_ien1 = wdat;
         end
         else if (hit(wb_req.adr, IDX_MODE))
         begin
            next_mode = wdat;
         end
         else if (hit(wb_req.adr, IDX_CTRL))
         begin
            next_ctrl = wdat & 8'h01;
         end
         else if (hit(wb_req.adr, IDX_EN))
         begin
            next_evt_en = wdat[NUM_EVT-1:0];
         end
         else if (hit(wb_req.adr, IDX_CLR))
         begin
            next_stat = (stat & ~wdat[NUM_EVT-1:0]) | {pin_evt, tmr_uf};
         end
      end
   end
   // bus answer; a write lands at the edge where the master samples ack
   always_comb
   begin
      next_ack = wb_req.cyc & wb_req.stb & ~wb_ack_o;
      next_dat = 32'h0000_0000;
      if (hit(wb_req.adr, IDX_CSS))
      begin
         next_dat[7:0] = css;
      end
      else if (hit(wb_req.adr, IDX_IEN1))
      begin
         next_dat[7:0] = ien1;
      end
      else if (hit(wb_req.adr, IDX_MODE))
      begin
         next_dat[7:0] = mode;
      end
      else if (hit(wb_req.adr, IDX_CTRL))
      begin
         next_dat[7:0] = ctrl;
      end
      else if (hit(wb_req.adr, IDX_STAT))
      begin
         next_dat[NUM_EVT-1:0] = stat;
      end
      else if (hit(wb_req.adr, IDX_EN))
      begin
         next_dat[NUM_EVT-1:0] = evt_en;
      end
      else if (hit(wb_req.adr, IDX_TMRX))
      begin
         next_dat[7:0] = tmr_cnt[T_X];
      end
      else if (hit(wb_req.adr, IDX_TMRY))
      begin
         next_dat[7:0] = tmr_cnt[T_Y];
      end
      else if (hit(wb_req.adr, IDX_TMR1))
      begin
         next_dat[7:0] = tmr_cnt[T_1];
      end
      else if (hit(wb_req.adr, IDX_TMR2))
      begin
         next_dat[7:0] = tmr_cnt[T_2];
      end
      // timer x and y interrupts also need their enable bits
      evt_gate = evt_en;
      evt_gate[T_X] = evt_en[T_X] & ien1[IEN1_X];
      evt_gate[T_Y] = evt_en[T_Y] & ien1[IEN1_Y];
      next_irq = |(next_stat & evt_gate);
   end

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         css      <= REG_RST;
         ien1     <= REG_RST;
         mode     <= REG_RST;
         ctrl     <= REG_RST;
         stat     <= '0;
         evt_en   <= '0;
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
         irq      <= 1'b0;
      end
      else
      begin
         css      <= next_css;
         ien1     <= next_ien1;
         mode     <= next_mode;
         ctrl     <= next_ctrl;
         stat     <= next_stat;
         evt_en   <= next_evt_en;
         wb_ack_o <= next_ack;
         wb_dat_o <= next_dat;
         irq      <= next_irq;
      end
   end
   // count sources
   logic [3:0] div_cnt;
   logic [3:0] next_div_cnt;
   logic       base_rise;
   logic       tick2;
   logic       tick16;
   logic       tick_sub;

   always_comb
   begin
      // low-speed mode swaps the divider input to the sub-oscillator
      base_rise    = ctrl[CTRL_LOW_SPEED] ? sub_rise : main_rise;
      next_div_cnt = base_rise ? div_cnt + 4'h1 : div_cnt;
      tick2        = base_rise & div_cnt[0];
      tick16       = base_rise & (div_cnt == DIV16_LAST);
      tick_sub     = sub_rise;
   end

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         div_cnt <= 4'h0;
      end
      else
      begin
         div_cnt <= next_div_cnt;
      end
   end
   // timers 1 and 2 have no stop bit and always count
   assign tmr_tick[T_1] = css[CSS_12] ? tick_sub : tick16;
   assign tmr_tick[T_2] = tmr_tick[T_1];
   // pin timers x and y
   logic [1:0] pin_out;
   logic [1:0] next_pin_out;
   logic [1:0] pin_drive;
   logic [1:0] next_pin_drive;

   genvar g;
   generate
      for (g = 0; g < 2; g++)
      begin : g_pin
         tux_mode_t md;
         logic      edge_sel;
         logic      stop;
         logic      src;
         assign md       = tux_mode_t'(mode[g*MODE_STRIDE +: 2]);
         assign edge_sel = mode[g*MODE_STRIDE + MODE_EDGE];
         assign stop     = mode[g*MODE_STRIDE + MODE_STOP];
         assign src      = css[g] ? tick2 : tick16;

         always_comb
         begin
            case (md)
               TUX_MODE_EVENT:
                  // rising edges on 0, falling edges on 1
                  tmr_tick[g] = ~stop & (edge_sel ? pin_fall[g] : pin_rise[g]);
               TUX_MODE_WIDTH:
                  // count only while the pin sits at the measured level
                  tmr_tick[g] = ~stop & src & (pin_lvl[g] == ~edge_sel);
               default:
                  tmr_tick[g] = ~stop & src;
            endcase
            // pin interrupt edge: falling on 0, rising on 1, in every mode
            pin_evt[g] = edge_sel ? pin_rise[g] : pin_fall[g];
            next_pin_drive[g] = (md == TUX_MODE_PULSE);
            if (md != TUX_MODE_PULSE || stop)
            begin
               // parked at the start level so a restart begins cleanly
               next_pin_out[g] = ~edge_sel;
            end
            else
            begin
               next_pin_out[g] = pin_out[g] ^ tmr_uf[g];
            end
         end
      end

      for (g = 0; g < NUM_TMR; g++)
      begin : g_tmr
         tux_down_timer u_tmr (
            .ref_clk   (ref_clk),
            .sys_rst   (sys_rst),
            .tick      (tmr_tick[g]),
            .load      (tmr_load[g]),
            .load_val  (wdat),
            .count     (tmr_cnt[g]),
            .underflow (tmr_uf[g])
         );
      end
   endgenerate
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         pin_out   <= 2'b11;
         pin_drive <= 2'b00;
      end
      else
      begin
         pin_out   <= next_pin_out;
         pin_drive <= next_pin_drive;
      end
   end

   assign ext_timer_pin_zero.pin_o    = pin_out[0];
   assign ext_timer_pin_zero.pin_oe_n = ~pin_drive[0];
   assign ext_timer_pin_one.pin_o     = pin_out[1];
   assign ext_timer_pin_one.pin_oe_n  = ~pin_drive[1];
endmodule : tux_timer_unit

// ===== verification/tux_pin_source.sv
// model of the pulse source with pull-up on one external timer pin
`timescale 1ns/1ns
module tux_pin_source
   import tux_pkg::*;
(
   // clock
   input wire logic    ref_clk,
   // unit drive in, resolved pin level out
   input tux_pin_drv_t drv,
   output logic        pin
);
   logic level = 1'b1;
   // the unit wins only while it enables its driver
   assign pin = (drv.pin_oe_n === 1'b0) ? drv.pin_o : level;
   task automatic hold(input logic v, input int n);
      level <= v;
      repeat (n) @(posedge ref_clk);
   endtask : hold
   task automatic pulses(input int k, input int w);
      repeat (k)
      begin
         hold(1'b0, w);
         hold(1'b1, w);
      end
   endtask : pulses
endmodule : tux_pin_source

// ===== verification/tux_timer_unit_properties.sv
// checker of bus handshake, reset state and pin drive of the timer unit
`timescale 1ns/1ns
module tux_timer_unit_properties
   import tux_pkg::*;
(
   // clock and reset
   input wire logic        ref_clk,
   input wire logic        sys_rst,
   // bus
   input tux_wb_req_t      wb_req,
   input wire logic        wb_ack_o,
   input wire logic [31:0] wb_dat_o,
   // pins and interrupt
   input tux_pin_drv_t     ext_timer_pin_zero,
   input tux_pin_drv_t     ext_timer_pin_one,
   input wire logic        irq
);
   logic [7:0] mode;
   logic [7:0] next_mode;
   // shadow of the mode register, loaded at the edge that takes the write
   always_comb
   begin
      next_mode = mode;
      if (wb_req.cyc && wb_req.stb && wb_req.we && wb_req.sel[0] && wb_ack_o
          && wb_req.adr == {IDX_MODE, 2'b00})
         next_mode = wb_req.dat[7:0];
   end
   always_ff @(posedge ref_clk)
   begin
      mode <= sys_rst ? REG_RST : next_mode;
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   sequence s_take;
      wb_req.cyc && wb_req.stb && !wb_ack_o;
   endsequence
   sequence s_one_ack;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   sequence s_park_x;
      ($stable(mode[3:0]) && mode[3] && mode[1:0] == TUX_MODE_PULSE) [*3];
   endsequence
   sequence s_park_y;
      ($stable(mode[7:4]) && mode[7] && mode[5:4] == TUX_MODE_PULSE) [*3];
   endsequence
   property p_ack_once;
      s_take |=> s_one_ack;
   endproperty
   property p_ack_cause;
      $rose(wb_ack_o) |-> $past(wb_req.cyc && wb_req.stb);
   endproperty
   property p_reset_state;
      $fell(sys_rst) |-> !wb_ack_o && !irq && ext_timer_pin_zero == 2'b11
         && ext_timer_pin_one == 2'b11;
   endproperty
   property p_css_read;
      wb_ack_o && $past(!wb_req.we && wb_req.adr == {IDX_CSS, 2'b00})
         |-> wb_dat_o[31:3] == 29'h0;
   endproperty
   // the pin register lags the mode register by one edge
   property p_drive_x;
      !ext_timer_pin_zero.pin_oe_n
         |-> mode[1:0] == TUX_MODE_PULSE || $past(mode[1:0]) == TUX_MODE_PULSE;
   endproperty
   property p_drive_y;
      !ext_timer_pin_one.pin_oe_n
         |-> mode[5:4] == TUX_MODE_PULSE || $past(mode[5:4]) == TUX_MODE_PULSE;
   endproperty
   property p_park_x;
      s_park_x |-> ext_timer_pin_zero.pin_o == !mode[2];
   endproperty
   property p_park_y;
      s_park_y |-> ext_timer_pin_one.pin_o == !mode[6];
   endproperty
   a_ack_once: assert property (p_ack_once) else $error("ack not one pulse");
   a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
   a_reset_state: assert property (p_reset_state) else $error("bad reset outputs");
   a_css_read: assert property (p_css_read) else $error("select upper bits set");
   a_drive_x: assert property (p_drive_x) else $error("pin 0 driven");
   a_drive_y: assert property (p_drive_y) else $error("pin 1 driven");
   a_park_x: assert property (p_park_x) else $error("pin 0 park level");
   a_park_y: assert property (p_park_y) else $error("pin 1 park level");
endmodule : tux_timer_unit_properties

bind tux_timer_unit tux_timer_unit_properties u_tux_timer_unit_properties (
   .ref_clk(ref_clk), .sys_rst(sys_rst), .wb_req(wb_req), .wb_ack_o(wb_ack_o),
   .wb_dat_o(wb_dat_o), .ext_timer_pin_zero(ext_timer_pin_zero),
   .ext_timer_pin_one(ext_timer_pin_one), .irq(irq));

// ===== verification/tux_timer_unit_test.sv
// self-checking bench of the four reload timers
`timescale 1ns/1ns
module tux_timer_unit_test
   import tux_pkg::*;
;
   logic         ref_clk;
   logic         sys_rst;
   tux_wb_req_t  wb_req;
   logic         wb_ack_o;
   logic [31:0]  wb_dat_o;
   logic         pin0;
   logic         pin1;
   tux_pin_drv_t drv0;
   tux_pin_drv_t drv1;
   logic         irq;
   logic [2:0]   osc_cnt = 3'h0;
   int           cyc_cnt;
   int           failures;
   int           tests_run;
   // main oscillator period 4 cycles, sub oscillator 8 cycles
   tux_timer_unit u_tux_timer_unit (.ref_clk(ref_clk), .sys_rst(sys_rst), .wb_req(wb_req),
      .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .main_osc_input(osc_cnt[1]),
      .sub_osc_input(osc_cnt[2]), .ext_timer_pin_zero_i(pin0), .ext_timer_pin_zero(drv0),
      .ext_timer_pin_one_i(pin1), .ext_timer_pin_one(drv1), .irq(irq));
   tux_pin_source u_tux_pin_source_0 (.ref_clk(ref_clk), .drv(drv0), .pin(pin0));
   tux_pin_source u_tux_pin_source_1 (.ref_clk(ref_clk), .drv(drv1), .pin(pin1));
   task automatic results();
      if (failures == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : results
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         failures++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic bus(input logic we, input logic [7:0] idx, input logic [7:0] wd,
                      output logic [7:0] rd);
      int n;
      wb_req <= '{1'b1, 1'b1, we, {idx, 2'b00}, 4'h1, {24'h0, wd}};
      n = 0;
      do
      begin
         @(posedge ref_clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      rd = wb_dat_o[7:0];
      if (n >= 50)
         chk(32'h0, 32'h1);
      wb_req <= '0;
      @(posedge ref_clk);
      // registered side effects of the write settle before the caller looks
      @(posedge ref_clk);
   endtask : bus
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [7:0] r;
      bus(1'b1, idx, d, r);
   endtask : wr
   task automatic rc(input logic [7:0] idx, input logic [7:0] e);
      logic [7:0] r;
      bus(1'b0, idx, 8'h00, r);
      chk(r, e);
   endtask : rc
   task automatic wait_irq();
      int n;
      n = 0;
      while (irq !== 1'b0 && n < 3000)
      begin
         @(posedge ref_clk);
         n++;
      end
      while (irq !== 1'b1 && n < 3000)
      begin
         @(posedge ref_clk);
         n++;
      end
      if (n >= 3000)
         chk(32'h0, 32'h1);
   endtask : wait_irq
   task automatic t_regs();
      rc(IDX_CSS, 8'h00);
      rc(IDX_IEN1, 8'h00);
      rc(IDX_MODE, 8'h00);
      wr(IDX_CSS, 8'hFF);
      rc(IDX_CSS, 8'h07);
      wr(IDX_IEN1, 8'hA5);
      rc(IDX_IEN1, 8'hA5);
      wr(IDX_IEN1, 8'h5A);
      rc(IDX_IEN1, 8'h5A);
      rc(8'hFF, 8'h00);
   endtask : t_regs
   // rise to rise of irq is one reload period, latch 3 gives 4 ticks
   task automatic t_period();
      logic [7:0] tix[4] = '{IDX_TMRX, IDX_TMRY, IDX_TMR1, IDX_TMR2};
      int tm[7] = '{0, 0, 1, 2, 2, 0, 3};
      int css[7] = '{0, 1, 2, 0, 4, 1, 0};
      int ctl[7] = '{0, 0, 0, 0, 0, 1, 1};
      int exp[7] = '{256, 32, 32, 256, 32, 64, 512};
      int t0;
      wr(IDX_IEN1, 8'hC0);
      for (int i = 0; i < 7; i++)
      begin
         wr(IDX_CTRL, 8'(ctl[i]));
         wr(IDX_CSS, 8'(css[i]));
         wr(IDX_EN, 8'(1 << tm[i]));
         wr(tix[tm[i]], 8'h03);
         wr(IDX_CLR, 8'h3F);
         wait_irq();
         t0 = cyc_cnt;
         wr(IDX_CLR, 8'h3F);
         wait_irq();
         chk(cyc_cnt - t0, exp[i]);
      end
      wr(IDX_CTRL, 8'h00);
   endtask : t_period
   task automatic t_gate();
      logic [7:0] r;
      wr(IDX_CSS, 8'h03);
      for (int i = 0; i < 2; i++)
      begin
         wr(IDX_EN, 8'(1 << i));
         wr(IDX_IEN1, 8'h80 >> i);
         wr(IDX_CLR, 8'h3F);
         repeat (100) @(posedge ref_clk);
         chk(irq, 1'b0);
         bus(1'b0, IDX_STAT, 8'h00, r);
         chk(r[i], 1'b1);
         wr(IDX_IEN1, 8'h40 << i);
         chk(irq, 1'b1);
      end
   endtask : t_gate
   // both pin timers parked while stopped, then toggling every 16 cycles
   task automatic t_pulse();
      int k;
      int j;
      logic p;
      logic q;
      wr(IDX_MODE, 8'h99);
      chk({drv0.pin_oe_n, drv0.pin_o}, 2'b01);
      chk({drv1.pin_oe_n, drv1.pin_o}, 2'b01);
      wr(IDX_MODE, 8'hDD);
      chk(pin0, 1'b0);
      chk(pin1, 1'b0);
      wr(IDX_TMRX, 8'h01);
      wr(IDX_TMRY, 8'h01);
      wr(IDX_MODE, 8'h55);
      k = 0;
      j = 0;
      p = pin0;
      q = pin1;
      repeat (160)
      begin
         @(posedge ref_clk);
         k += (pin0 !== p);
         j += (pin1 !== q);
         p = pin0;
         q = pin1;
      end
      chk(k >= 9 && k <= 11, 1'b1);
      chk(j >= 9 && j <= 11, 1'b1);
      // release both pins while in timer mode so no stray edge reaches the event test
      wr(IDX_MODE, 8'h00);
   endtask : t_pulse
   task automatic t_event();
      logic [7:0] r;
      wr(IDX_MODE, 8'h28);
      wr(IDX_TMRY, 8'h09);
      wr(IDX_CLR, 8'h3F);
      u_tux_pin_source_1.pulses(4, 6);
      rc(IDX_TMRY, 8'h05);
      bus(1'b0, IDX_STAT, 8'h00, r);
      chk(r[5], 1'b1);
      wr(IDX_MODE, 8'h68);
      wr(IDX_TMRY, 8'h09);
      u_tux_pin_source_1.pulses(3, 3);
      rc(IDX_TMRY, 8'h06);
      wr(IDX_MODE, 8'hE8);
      u_tux_pin_source_1.pulses(2, 9);
      rc(IDX_TMRY, 8'h06);
   endtask : t_event
   // measured level lasts 80 cycles, ten ticks of 8 cycles each
   task automatic t_width();
      logic [7:0] r;
      for (int e = 0; e < 2; e++)
      begin
         u_tux_pin_source_0.hold(1'(e), 1);
         wr(IDX_MODE, 8'(3 + 4 * e));
         wr(IDX_TMRX, 8'hC8);
         u_tux_pin_source_0.hold(!e, 80);
         u_tux_pin_source_0.hold(1'(e), 30);
         bus(1'b0, IDX_TMRX, 8'h00, r);
         chk(r >= 8'hBD && r <= 8'hBF, 1'b1);
      end
   endtask : t_width
   initial
   begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk)
   begin
      osc_cnt <= osc_cnt + 3'h1;
      cyc_cnt <= cyc_cnt + 1;
   end
   initial
   begin
      repeat (60000) @(posedge ref_clk);
      chk(32'h0, 32'h1);
      results();
   end
   initial
   begin
      sys_rst = 1'b1;
      wb_req = '0;
      repeat (4) @(posedge ref_clk);
      sys_rst <= 1'b0;
      @(posedge ref_clk);
      t_regs();
      t_period();
      t_gate();
      t_pulse();
      t_event();
      t_width();
      sys_rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      sys_rst <= 1'b0;
      @(posedge ref_clk);
      rc(IDX_CSS, 8'h00);
      results();
   end
endmodule : tux_timer_unit_test
